/* File: char_disp_pkg.sv */
// Constants for the character display controller
// Operation
// [RQ1] Drives a character display of 16 columns by 2 lines.
// [RQ2] Data go over an eight-bit parallel bus, bits 7 down to 0.
// [RQ3] Strobe, direction and select each come from their own output.
// [RQ4] Select line picks data register or command register.
// [RQ5] Command register read returns busy indication on bit 7.
// [RQ6] Host polls busy and waits till clear before each command.
// [RQ7] Interrupt rises a short delay after read data is valid.
// [RQ8] Select and direction settle before strobe; write data outlives strobe.
package char_disp_pkg;
    // ------------------------------------------------------------
    // Display geometry and bus widths
    // ------------------------------------------------------------
    localparam int DISP_COLS = 16;
    localparam int DISP_LINES = 2;
    localparam int DBW = 8;
    localparam int BUSY_BIT = 7;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int AW = 5;
    localparam logic [AW-1:0] OFS_CMD = 5'h00;
    localparam logic [AW-1:0] OFS_DATA = 5'h04;
    localparam logic [AW-1:0] OFS_ISTAT = 5'h08;
    localparam logic [AW-1:0] OFS_IMASK = 5'h0C;
    localparam logic SEL_CMD = 1'h0;
    localparam logic SEL_DATA = 1'h1;
    localparam logic IMASK_RST = 1'h0;
    // ------------------------------------------------------------
    // Display bus timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int T_SETUP_NS = 60;
    localparam int T_PULSE_NS = 450;
    localparam int T_HOLD_NS = 20;
    localparam int IRQ_DELAY_CYC = 4;
    localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int CW = 8;
    localparam logic [CW-1:0] SETUP_LD = CW'(SETUP_CYC - 1);
    localparam logic [CW-1:0] PULSE_LD = CW'(PULSE_CYC - 1);
    localparam logic [CW-1:0] HOLD_LD = CW'(HOLD_CYC - 1);
    localparam logic [CW-1:0] IRQ_LD = CW'(IRQ_DELAY_CYC);
    typedef enum logic [2:0] {ST_IDLE, ST_DATA, ST_SETUP, ST_PULSE, ST_HOLD} state_t;
endpackage : char_disp_pkg

/* File: char_display_controller.sv */
// Character display controller with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
module char_display_controller
    import char_disp_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    // AHB-Lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Display bus
    input wire logic [DBW-1:0] DISPLAY_DATA_BUS_I,
    output logic [DBW-1:0] CHAR_DISPLAY_DATA_OUT_O,
    output logic DISPLAY_DATA_BUS_OE_O,
    output logic DISPLAY_STROBE_DRIVE_O,
    output logic DISPLAY_DIRECTION_DRIVE_O,
    output logic DISPLAY_REGSEL_DRIVE_O,
    // Interrupt
    output logic IRQ_O
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    state_t state_q;
    logic [AW-1:0] addr_q;
    logic wr_q;
    logic ready_q;
    logic resp_q;
    logic [31:0] rdata_q;
    logic [CW-1:0] cnt_q;
    logic strobe_q;
    logic dir_q;
    logic regsel_q;
    logic [DBW-1:0] dout_q;
    logic oe_q;
    logic [DBW-1:0] sync1_q;
    logic [DBW-1:0] sync2_q;
    logic [DBW-1:0] sync3_q;
    logic [DBW-1:0] stable_q;
    logic stat_q;
    logic mask_q;
    logic irq_q;
    logic [CW-1:0] idly_q;
    wire accept = HSEL_I && HTRANS_I[1] && HREADY_I && ready_q;
    wire is_cmd = (addr_q == OFS_CMD);
    wire is_dat = (addr_q == OFS_DATA);
    wire is_disp = is_cmd || is_dat;
    wire is_stat = (addr_q == OFS_ISTAT);
    wire is_mask = (addr_q == OFS_IMASK);
    wire in_data = (state_q == ST_DATA);
    wire cnt_done = (cnt_q == '0);
    wire pulse_end = (state_q == ST_PULSE) && cnt_done;
    wire rd_capture = pulse_end && dir_q;
    wire stat_clr = in_data && !wr_q && is_stat;
    wire idly_fire = (idly_q == CW'(1));
    wire stat_d = (stat_q && !stat_clr) || idly_fire;
    wire mask_d = (in_data && wr_q && is_mask) ? HWDATA_I[0] : mask_q;
    wire [31:0] local_rd = is_stat ? {31'h0, stat_q} : is_mask ? {31'h0, mask_q} : 32'h0;
    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    // The bus stalls for the whole display cycle, so software cannot
    // overlap accesses; polling busy is still its job.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            state_q <= ST_IDLE;
            addr_q <= '0;
            wr_q <= 1'b0;
            ready_q <= 1'b1;
            cnt_q <= '0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (accept)
                    begin
                        addr_q <= HADDR_I[AW-1:0];
                        wr_q <= HWRITE_I;
                        ready_q <= 1'b0;
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA:
                begin
                    if (is_disp)
                    begin
                        cnt_q <= SETUP_LD;
                        state_q <= ST_SETUP;
                    end
                    else
                    begin
                        ready_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                ST_SETUP:
                begin
                    cnt_q <= cnt_done ? PULSE_LD : cnt_q - CW'(1);
                    if (cnt_done)
                        state_q <= ST_PULSE; // RQ8
                end
                ST_PULSE:
                begin
                    cnt_q <= cnt_done ? HOLD_LD : cnt_q - CW'(1);
                    if (cnt_done)
                        state_q <= ST_HOLD;
                end
                ST_HOLD:
                begin
                    cnt_q <= cnt_q - CW'(1);
                    if (cnt_done)
                    begin
                        ready_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // Display pin drive
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            strobe_q <= 1'b0;
            dir_q <= 1'b0;
            regsel_q <= SEL_CMD;
            dout_q <= '0;
            oe_q <= 1'b0;
        end
        else
        begin
            if (in_data && is_disp)
            begin
                regsel_q <= is_dat ? SEL_DATA : SEL_CMD; // RQ4
                dir_q <= !wr_q; // RQ3
                dout_q <= HWDATA_I[DBW-1:0]; // RQ2
                oe_q <= wr_q; // RQ2
            end
            if ((state_q == ST_SETUP) && cnt_done)
                strobe_q <= 1'b1; // RQ3
            if (pulse_end)
                strobe_q <= 1'b0;
            // Write data stays on until the hold time has passed
            if ((state_q == ST_HOLD) && cnt_done)
                oe_q <= 1'b0; // RQ8
        end
    end
    // ------------------------------------------------------------
    // Read data synchroniser
    // ------------------------------------------------------------
    // A byte counts only once two late stages agree, which filters
    // skew between the eight pins at the cost of four cycles.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            stable_q <= '0;
        end
        else
        begin
            sync1_q <= DISPLAY_DATA_BUS_I;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q)
                stable_q <= sync3_q;
        end
    end
    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            rdata_q <= '0;
            resp_q <= 1'b0;
        end
        else
        begin
            resp_q <= 1'b0;
            if (in_data && !wr_q && !is_disp)
                rdata_q <= local_rd;
            // Captured while the strobe is still high; bit 7 is busy on command reads
            if (rd_capture)
                rdata_q <= {24'h0, stable_q}; // RQ5 RQ8 RQ1
        end
    end
    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            idly_q <= '0;
            stat_q <= 1'b0;
            mask_q <= IMASK_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            if (rd_capture)
                idly_q <= IRQ_LD; // RQ7
            else if (idly_q != '0)
                idly_q <= idly_q - CW'(1);
            stat_q <= stat_d; // RQ7
            mask_q <= mask_d;
            irq_q <= stat_d && mask_d; // RQ7
        end
    end
    assign HRDATA_O = rdata_q;
    assign HREADYOUT_O = ready_q;
    assign HRESP_O = resp_q;
    assign CHAR_DISPLAY_DATA_OUT_O = dout_q;
    assign DISPLAY_DATA_BUS_OE_O = oe_q;
    assign DISPLAY_STROBE_DRIVE_O = strobe_q;
    assign DISPLAY_DIRECTION_DRIVE_O = dir_q;
    assign DISPLAY_REGSEL_DRIVE_O = regsel_q;
    assign IRQ_O = irq_q;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    sequence strobe_rise_s;
        $rose(strobe_q);
    endsequence
    sequence read_capture_s;
        $fell(strobe_q) && dir_q;
    endsequence
    setup_stable_a: assert property (strobe_rise_s |-> $stable(regsel_q) && $stable(dir_q) // RQ8
        && $past(state_q) == ST_SETUP)
        else $error("select or direction moved at strobe rise");
    write_hold_a: assert property ($fell(strobe_q) && !dir_q |-> oe_q[*3]) // RQ8
        else $error("write data released too early");
    read_nodrive_a: assert property (dir_q |-> !oe_q) // RQ2
        else $error("controller drives bus during read");
    pulse_width_a: assert property (strobe_rise_s |-> strobe_q[*8]) // RQ3
        else $error("strobe pulse too short");
    write_data_a: assert property (strobe_q && !dir_q |-> $stable(dout_q) && oe_q) // RQ2
        else $error("write data changed under strobe");
    regsel_map_a: assert property ($rose(state_q == ST_SETUP) |-> regsel_q == (addr_q == OFS_DATA)) // RQ4
        else $error("register select does not match address");
    busy_bit_a: assert property (read_capture_s |-> rdata_q[BUSY_BIT] == $past(stable_q[BUSY_BIT])) // RQ5
        else $error("busy bit not returned on bit 7");
    irq_delay_a: assert property (read_capture_s |-> ##[1:8] stat_q) // RQ7
        else $error("read event not flagged");
    irq_out_a: assert property (irq_q == (stat_q && mask_q)) // RQ7
        else $error("interrupt output disagrees with status and mask");
    bus_stall_a: assert property (state_q inside {ST_SETUP, ST_PULSE} |-> !ready_q) // RQ6
        else $error("bus released during display cycle");
    // ------------------------------------------------------------
    // Sequencing checks
    // ------------------------------------------------------------
    // Repetition counts track SETUP_CYC and HOLD_CYC; retune them together
    sequence hold_done_s;
        (state_q == ST_HOLD) && cnt_done;
    endsequence
    strobe_window_a: assert property (strobe_q == (state_q == ST_PULSE)) // RQ3
        else $error("strobe high outside its pulse phase");
    setup_len_a: assert property ($rose(state_q == ST_SETUP) |-> !strobe_q[*8] ##1 strobe_q) // RQ8
        else $error("setup time before strobe is wrong");
    hold_len_a: assert property ($fell(strobe_q) |-> !ready_q[*3] ##1 ready_q) // RQ8
        else $error("hold time after strobe is wrong");
    ready_after_hold_a: assert property (hold_done_s |=> ready_q && !oe_q) // RQ8
        else $error("cycle did not end after hold");
    local_wait_a: assert property (in_data && !is_disp |=> ready_q) // RQ6
        else $error("local register access not answered in one wait state");
    read_nodata_a: assert property (in_data && !wr_q && is_disp |=> !oe_q && dir_q) // RQ3
        else $error("read cycle set up with wrong direction");
    stat_sticky_a: assert property (stat_q && !stat_clr |=> stat_q) // RQ7
        else $error("status bit lost without a read");
    stat_clear_a: assert property (stat_clr && !idly_fire |=> !stat_q) // RQ7
        else $error("status bit not cleared by read");
    sync_agree_a: assert property (sync2_q == sync3_q |=> stable_q == $past(sync3_q)) // RQ2
        else $error("agreed pin byte not taken");
    addr_hold_a: assert property (!ready_q && !$past(ready_q) |-> $stable(addr_q) && $stable(wr_q)) // RQ4
        else $error("access target changed during stall");
    data_idle_a: assert property (state_q == ST_IDLE |-> !oe_q && !strobe_q) // RQ2
        else $error("display bus active while idle");
endmodule : char_display_controller

/* File: disp_model.sv */
// Behavioural model of the character display on the far side
module disp_model
    import char_disp_pkg::*;
#(
    parameter int BUSY_CYC = 150
)
(
    // Display pins
    input wire logic clk_i,
    input wire logic strobe_i,
    input wire logic dir_i,
    input wire logic regsel_i,
    input wire logic [DBW-1:0] data_i,
    output logic [DBW-1:0] data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DBW:0] wq[$];
    logic [DBW-1:0] cmd_q = 8'h00;
    logic [DBW-1:0] dat_q = 8'h00;
    logic stb_p = 1'b0;
    int busy_n = 0;
    initial data_o = 8'hA5;
    // Sampled on the falling edge so the registered pins have settled
    always @(negedge clk_i)
    begin
        if (busy_n > 0) busy_n--;
        if (stb_p && !strobe_i && !dir_i)
        begin
            wq.push_back({regsel_i, data_i});
            if (regsel_i == SEL_DATA) dat_q = data_i;
            else
            begin
                cmd_q = data_i;
                busy_n = BUSY_CYC;
            end
        end
        // Released bus toggles so a stale byte never passes for data
        if (strobe_i && dir_i) data_o <= (regsel_i == SEL_DATA) ? dat_q : {busy_n > 0, cmd_q[6:0]};
        else data_o <= ~data_o;
        stb_p = strobe_i;
    end
endmodule : disp_model

/* File: tb.sv */
// Self-checking testbench for the character display controller
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb
    import char_disp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hresp, stb, dir, sel, oe, irq;
    logic stb_p = 0, dir_p = 0, sel_p = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r, seed = 32'hD34A;
    logic [7:0] dout, din, do_p = 0, c;
    logic [8:0] exp_q[$];
    int failures = 0, total_checks = 0, n, k;
    localparam logic [31:0] A_CMD = 32'(OFS_CMD), A_DAT = 32'(OFS_DATA);
    localparam logic [31:0] A_IST = 32'(OFS_ISTAT), A_IMK = 32'(OFS_IMASK);
    always #4 clk = ~clk;
    char_display_controller DUT (.SYS_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .DISPLAY_DATA_BUS_I(din),
        .CHAR_DISPLAY_DATA_OUT_O(dout), .DISPLAY_DATA_BUS_OE_O(oe), .DISPLAY_STROBE_DRIVE_O(stb),
        .DISPLAY_DIRECTION_DRIVE_O(dir), .DISPLAY_REGSEL_DRIVE_O(sel), .IRQ_O(irq));
    disp_model u_disp (.clk_i(clk), .strobe_i(stb), .dir_i(dir), .regsel_i(sel), .data_i(dout), .data_o(din));
    // ----
    // Pin timing monitor
    // ----
    always @(negedge clk)
    begin
        if (stb) `CHK("ctl", {dir_p, sel_p}, {dir, sel})
        if (stb_p && !stb && !dir) `CHK("wdata", {1'b1, do_p}, {oe, dout})
        stb_p = stb;
        dir_p = dir;
        sel_p = sel;
        do_p = dout;
    end
    // ----
    // Bus tasks
    // ----
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task final_report;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    // Ready is read at the falling edge, where it equals what the next rising edge samples
    task wait_rdy;
        logic rd;
        n = 0;
        rd = 0;
        while (!rd)
        begin
            @(negedge clk);
            rd = hready;
            r = hrdata;
            @(posedge clk);
            n++;
            if (n > 500)
            begin
                failures++;
                final_report();
            end
        end
    endtask : wait_rdy
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= 2'h2;
        hsize <= 3'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        `CHK("hresp", 1'b0, hresp)
    endtask : ahb
    // ----
    // Main sequence
    // ----
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 0;
        @(negedge clk);
        `CHK("rst", 3'b100, {hready, irq, stb})
        @(posedge clk);
        ahb(0, A_IMK, 0);
        `CHK("imask", 32'(IMASK_RST), r)
        ahb(1, 32'h10, 32'hFFFF_FFFF);
        ahb(0, 32'h10, 0);
        `CHK("unmapped", 32'h0, r)
        seed = lfsr(seed);
        c = seed[7:0];
        ahb(1, A_CMD, seed);
        exp_q.push_back({SEL_CMD, c});
        ahb(0, A_CMD, 0);
        `CHK("busy", {24'h0, 1'b1, c[6:0]}, r)
        for (k = 0; k < 40 && r[BUSY_BIT]; k++) ahb(0, A_CMD, 0);
        `CHK("idle", {24'h0, 1'b0, c[6:0]}, r)
        `CHK("irq masked", 1'b0, irq)
        ahb(0, A_IST, 0);
        `CHK("istat", 32'h1, r)
        ahb(0, A_IST, 0);
        `CHK("istat clr", 32'h0, r)
        ahb(1, A_IMK, 1);
        ahb(0, A_CMD, 0);
        repeat (IRQ_DELAY_CYC + 2) @(posedge clk);
        @(negedge clk);
        `CHK("irq", 1'b1, irq)
        @(posedge clk);
        ahb(0, A_IST, 0);
        @(negedge clk);
        `CHK("irq clr", {32'h1, 1'b0}, {r, irq})
        @(posedge clk);
        for (k = 0; k < DISP_COLS * DISP_LINES; k++)
        begin
            seed = lfsr(seed);
            c = seed[7:0];
            ahb(1, A_DAT, seed);
            exp_q.push_back({SEL_DATA, c});
        end
        ahb(0, A_DAT, 0);
        `CHK("rdata", {24'h0, c}, r)
        `CHK("nwr", exp_q.size(), u_disp.wq.size())
        foreach (exp_q[i]) `CHK("wr", exp_q[i], u_disp.wq[i])
        final_report();
    end
endmodule : tb
